/* flash_spi_regs.vh */
// constants for the serial flash front end: pin-side commands, status layout,
// register map of the AXI4-Lite control port and memory geometry.
// assumes one 100 MHz system clock and an external SPI master on the pins.
`ifndef FLASH_SPI_REGS_VH
`define FLASH_SPI_REGS_VH

// serial commands
`define CMD_WRITE_STATUS 8'h01
`define CMD_READ_DATA 8'h03
`define CMD_WRITE_DISABLE 8'h04
`define CMD_READ_STATUS 8'h05
`define CMD_WRITE_ENABLE 8'h06

// status byte layout
`define ST_BUSY 0
`define ST_WEL 1
`define ST_BP_LO 2
`define ST_BP_HI 5
`define ST_AAI 6
`define ST_LOCK 7
`define BP_RESET 4'hF
`define LOCK_RESET 1'b0

// AXI4-Lite register byte offsets
`define REG_CTRL 6'h00
`define REG_STATUS 6'h04
`define REG_TX_DATA 6'h08
`define REG_RX 6'h0C
`define REG_ADDR 6'h10
`define REG_GEOM 6'h14

// control register bits
`define CTRL_BUSY 0
`define CTRL_AAI 1
`define CTRL_RB_EN 2

// geometry: address shifts for 4K sector, 32K and 64K blocks
`define SECTOR_SHIFT 12
`define BLK32_SHIFT 15
`define BLK64_SHIFT 16

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* flash_pin_sync.v */
// three-stage synchroniser for asynchronous pin inputs.
// output follows only when stages two and three agree.
`timescale 1ns/1ps
module flash_pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // pins in, filtered levels out
  input wire [W-1:0] i_pin,
  output wire [W-1:0] o_lvl
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg f_q;
      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          s1_q <= RST_VAL[g];
          s2_q <= RST_VAL[g];
          s3_q <= RST_VAL[g];
          f_q <= RST_VAL[g];
        end else begin
          s1_q <= i_pin[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            f_q <= s3_q;
          end
        end
      end
      assign o_lvl[g] = f_q;
    end
  endgenerate

endmodule // flash_pin_sync

/* flash_spi_front.v */
// serial flash SPI front end: pin sampling, shifting, pause, status
// register write protection, and an AXI4-Lite control port.
// assumes SCK well below a quarter of I_REF_CLK; pins are asynchronous.
`timescale 1ns/1ps
`include "flash_spi_regs.vh"
module flash_spi_front (
  // system
  input wire I_REF_CLK,
  input wire I_ARST_N,
  // serial pins
  input wire I_SCK,
  input wire I_CE_N,
  input wire I_SI,
  input wire I_HOLD_N,
  input wire I_WP_N,
  output wire O_SO,
  output wire O_SO_OE,
  // axi4-lite write address and data
  input wire I_AWVALID,
  output wire O_AWREADY,
  input wire [5:0] I_AWADDR,
  input wire I_WVALID,
  output wire O_WREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  // axi4-lite write response
  output wire O_BVALID,
  input wire I_BREADY,
  output wire [1:0] O_BRESP,
  // axi4-lite read
  input wire I_ARVALID,
  output wire O_ARREADY,
  input wire [5:0] I_ARADDR,
  output wire O_RVALID,
  input wire I_RREADY,
  output wire [31:0] O_RDATA,
  output wire [1:0] O_RRESP
);

  localparam PH_CMD = 2'h0;
  localparam PH_ADDR = 2'h1;
  localparam PH_DATA = 2'h2;

  // filtered pin levels
  wire sck_f;
  wire ce_n_f;
  wire si_f;
  wire hold_n_f;
  wire wp_n_f;

  // pins idle high except the clock and data
  flash_pin_sync #(
    .W(5),
    .RST_VAL(5'h1C)
  ) u_sync (
    .i_clk(I_REF_CLK),
    .i_arst_n(I_ARST_N),
    .i_pin({I_WP_N, I_HOLD_N, I_CE_N, I_SI, I_SCK}),
    .o_lvl({wp_n_f, hold_n_f, ce_n_f, si_f, sck_f})
  );

  reg sck_p_q;
  reg ce_n_p_q;
  reg sel_q;
  reg hold_q;
  reg mode3_q;
  reg [1:0] phase_q;
  reg [2:0] bit_q;
  reg [1:0] abyte_q;
  reg [7:0] rx_q;
  reg [7:0] cmd_q;
  reg [7:0] last_q;
  reg [23:0] addr_q;
  reg [7:0] tx_q;
  reg [2:0] tx_cnt_q;
  reg drive_q;
  reg so_q;
  reg wel_q;
  reg [3:0] bp_q;
  reg lock_q;
  reg [2:0] ctrl_q;
  reg [7:0] tx_data_q;

  wire sck_rise = sck_f & ~sck_p_q;
  wire sck_fall = ~sck_f & sck_p_q;
  wire ce_fall = ~ce_n_f & ce_n_p_q;
  wire active = sel_q & ~ce_n_f & ~hold_q;
  wire [7:0] rx_next = {rx_q[6:0], si_f};
  wire byte_done = active & sck_rise & (bit_q == 3'h7);
  wire busy = ctrl_q[`CTRL_BUSY];
  wire auto_increment_program = ctrl_q[`CTRL_AAI];
  wire locked = ~wp_n_f & lock_q;
  wire rb_mode = auto_increment_program & ctrl_q[`CTRL_RB_EN];
  wire [7:0] status = {lock_q, auto_increment_program, bp_q, wel_q, busy};

  // edge history always tracks, so no false edge after pause
  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sck_p_q <= 1'b0;
      ce_n_p_q <= 1'b1;
    end else begin
      sck_p_q <= sck_f;
      ce_n_p_q <= ce_n_f;
    end
  end

  // selection and pause
  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sel_q <= 1'b0;
      hold_q <= 1'b0;
      mode3_q <= 1'b0;
    end else if (ce_n_f) begin
      sel_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      if (ce_fall) begin
        sel_q <= 1'b1;
        mode3_q <= sck_f;
      end
      // pause changes state only at clock-low phase
      if (sel_q && !sck_f) begin
        hold_q <= ~hold_n_f;
      end
    end
  end

  // input shifter, sequence position frozen while paused
  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      phase_q <= PH_CMD;
      bit_q <= 3'h0;
      abyte_q <= 2'h0;
      rx_q <= 8'h00;
      cmd_q <= 8'h00;
      last_q <= 8'h00;
      addr_q <= 24'h000000;
    end else if (ce_n_f || ce_fall) begin
      phase_q <= PH_CMD;
      bit_q <= 3'h0;
      abyte_q <= 2'h0;
    end else if (active && sck_rise) begin
      rx_q <= rx_next;
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        last_q <= rx_next;
        case (phase_q)
          PH_CMD: begin
            cmd_q <= rx_next;
            if (rx_next == `CMD_READ_DATA) begin
              phase_q <= PH_ADDR;
            end else begin
              phase_q <= PH_DATA;
            end
          end
          PH_ADDR: begin
            addr_q <= {addr_q[15:0], rx_next};
            abyte_q <= abyte_q + 2'h1;
            if (abyte_q == 2'h2) begin
              phase_q <= PH_DATA;
            end
          end
          PH_DATA: begin
            phase_q <= PH_DATA;
          end
          default: begin
            phase_q <= PH_CMD;
          end
        endcase
      end
    end
  end

  // status register: enable latch, block protect and lock
  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      wel_q <= 1'b0;
      bp_q <= `BP_RESET;
      lock_q <= `LOCK_RESET;
    end else if (byte_done) begin
      if (phase_q == PH_CMD) begin
        if (rx_next == `CMD_WRITE_ENABLE) begin
          wel_q <= 1'b1;
        end else if (rx_next == `CMD_WRITE_DISABLE) begin
          wel_q <= 1'b0;
        end
      end else if (phase_q == PH_DATA && cmd_q == `CMD_WRITE_STATUS) begin
        wel_q <= 1'b0;
        // refused when pin low and lock set, so lock holds itself
        if (wel_q && !busy && !locked) begin
          bp_q <= rx_next[`ST_BP_HI:`ST_BP_LO];
          lock_q <= rx_next[`ST_LOCK];
        end
      end
    end
  end

  // output shifter, loaded at rise, shifted out on falls
  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tx_q <= 8'h00;
      tx_cnt_q <= 3'h0;
      drive_q <= 1'b0;
      so_q <= 1'b0;
    end else if (ce_n_f || ce_fall) begin
      drive_q <= 1'b0;
      tx_cnt_q <= 3'h0;
    end else if (byte_done && !drive_q) begin
      if (phase_q == PH_CMD && rx_next == `CMD_READ_STATUS) begin
        tx_q <= status;
        drive_q <= 1'b1;
      end else if (phase_q == PH_ADDR && abyte_q == 2'h2) begin
        tx_q <= tx_data_q;
        drive_q <= 1'b1;
      end
    end else if (active && sck_fall && drive_q) begin
      so_q <= tx_q[7];
      tx_cnt_q <= tx_cnt_q + 3'h1;
      if (tx_cnt_q == 3'h7) begin
        // status repeats; data repeats the software byte
        if (cmd_q == `CMD_READ_STATUS) begin
          tx_q <= status;
        end else begin
          tx_q <= tx_data_q;
        end
      end else begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ready/busy shows low while busy, only outside a read
  assign O_SO = drive_q ? so_q : ~busy;
  assign O_SO_OE = sel_q & ~ce_n_f & ~hold_q & (drive_q | rb_mode);

  // axi4-lite slave
  reg aw_have_q;
  reg w_have_q;
  reg [5:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg [31:0] rd_d;
  reg rd_ok_d;

  assign O_AWREADY = ~aw_have_q & ~bvalid_q;
  assign O_WREADY = ~w_have_q & ~bvalid_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_ARREADY = ~rvalid_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;

  wire do_write = aw_have_q & w_have_q & ~bvalid_q;
  wire wr_ctrl = do_write && awaddr_q == `REG_CTRL;
  wire wr_tx = do_write && awaddr_q == `REG_TX_DATA;

  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_have_q <= 1'b1;
        awaddr_q <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_have_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        if (wr_ctrl || wr_tx) begin
          bresp_q <= `RESP_OKAY;
        end else begin
          bresp_q <= `RESP_SLVERR;
        end
      end else if (bvalid_q && I_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // software-driven busy and program mode steer the pin logic
  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl_q <= 3'h0;
      tx_data_q <= 8'h00;
    end else begin
      if (wr_ctrl && wstrb_q[0]) begin
        ctrl_q <= wdata_q[2:0];
      end
      if (wr_tx && wstrb_q[0]) begin
        tx_data_q <= wdata_q[7:0];
      end
    end
  end

  always @* begin
    rd_d = 32'h00000000;
    rd_ok_d = 1'b1;
    case (I_ARADDR)
      `REG_CTRL: begin
        rd_d = {29'h00000000, ctrl_q};
      end
      `REG_STATUS: begin
        rd_d = {24'h000000, status};
      end
      `REG_TX_DATA: begin
        rd_d = {24'h000000, tx_data_q};
      end
      `REG_RX: begin
        rd_d = {13'h0000, hold_q, mode3_q, sel_q, last_q, cmd_q};
      end
      `REG_ADDR: begin
        rd_d = {8'h00, addr_q};
      end
      `REG_GEOM: begin
        rd_d[7:0] = addr_q[`BLK64_SHIFT+7:`BLK64_SHIFT];
        rd_d[15:8] = addr_q[`BLK32_SHIFT+7:`BLK32_SHIFT];
        rd_d[27:16] = addr_q[`SECTOR_SHIFT+11:`SECTOR_SHIFT];
      end
      default: begin
        rd_ok_d = 1'b0;
      end
    endcase
  end

  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_d;
      rresp_q <= rd_ok_d ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && I_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // flash_spi_front

/* flash_front_chk.sv */
// checker for the flash front end: bus handshakes and serial pin timing.
// assumes pins reach the block through its own synchronisers.
`timescale 1ns/1ps
module flash_front_chk (
  // system
  input wire I_REF_CLK,
  input wire I_ARST_N,
  // serial pins
  input wire I_SCK,
  input wire I_CE_N,
  input wire I_HOLD_N,
  input wire O_SO,
  input wire O_SO_OE,
  // bus
  input wire I_ARVALID,
  input wire O_ARREADY,
  input wire O_AWREADY,
  input wire O_WREADY,
  input wire O_BVALID,
  input wire I_BREADY,
  input wire [1:0] O_BRESP,
  input wire O_RVALID,
  input wire I_RREADY,
  input wire [31:0] O_RDATA
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);
  // eight cycles covers the pin filter plus one register
  a_idle_no_drive: assert property (I_CE_N [*8] |-> !O_SO_OE)
    else $error("so driven while deselected");
  a_pause_float: assert property ((!I_HOLD_N && !I_SCK) [*8] |-> !O_SO_OE)
    else $error("so driven while paused");
  a_so_fall_only: assert property (O_SO_OE && $past(O_SO_OE) && $changed(O_SO) |-> !I_SCK)
    else $error("so changed while clock high");
  a_b_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  a_r_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  a_r_latency: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  a_ar_block: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read taken while busy");
  a_b_block: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while busy");
endmodule // flash_front_chk

bind flash_spi_front flash_front_chk chk_u (
  .I_REF_CLK(I_REF_CLK),
  .I_ARST_N(I_ARST_N),
  .I_SCK(I_SCK),
  .I_CE_N(I_CE_N),
  .I_HOLD_N(I_HOLD_N),
  .O_SO(O_SO),
  .O_SO_OE(O_SO_OE),
  .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY),
  .O_AWREADY(O_AWREADY),
  .O_WREADY(O_WREADY),
  .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY),
  .O_BRESP(O_BRESP),
  .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY),
  .O_RDATA(O_RDATA)
);

/* spi_host_model.sv */
// serial bus master model: clock, select, data and pause pins.
// assumes the output line is resolved by the bench, pulled high.
`timescale 1ns/1ps
module spi_host_model (
  // resolved flash output
  input wire i_so,
  // driven pins
  output logic o_sck,
  output logic o_ce_n,
  output logic o_si,
  output logic o_hold_n
);
  bit m3;
  initial begin
    o_sck = 0;
    o_ce_n = 1;
    o_si = 0;
    o_hold_n = 1;
  end
  task automatic sel(input bit m);
    // keep every pin edge off the system clock edge
    #2;
    m3 = m;
    o_sck = m;
    #125 o_ce_n = 0;
    #125;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sck = 0;
      o_si = tx[i];
      #62.5 o_sck = 1;
      rx[i] = i_so;
      #62.5;
    end
    if (!m3) o_sck = 0;
  endtask
  task automatic hold(input bit v);
    #100 o_hold_n = v;
    #250;
  endtask
  // clock and data wiggle that a paused device must ignore
  task automatic wig();
    repeat (3) begin
      #62.5 o_sck = 1;
      o_si = ~o_si;
      #62.5 o_sck = 0;
    end
    #250;
  endtask
  task automatic desel();
    #62.5 o_ce_n = 1;
    o_si = ~o_si;
    #250;
  endtask
endmodule // spi_host_model

/* test_serial_flash_spi_front_end.sv */
// bench for the flash front end: bus master tasks, serial host model, status model.
// assumes a 100 MHz system clock and a 125 ns serial clock.
`timescale 1ns/1ps
`include "flash_spi_regs.vh"
module test_serial_flash_spi_front_end;
  logic clk = 0, arst_n = 0, wp_n = 1;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [5:0] awa = 6'h00, ara = 6'h00;
  logic [31:0] wd = 32'h0, seed = 32'd26;
  logic [3:0] wstrb = 4'hF;
  wire sck, ce_n, si, hold_n, so, so_oe, awr, wr, bv, arr, rv;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire so_w = so_oe ? so : 1'b1;
  int errors = 0, cmp_count = 0;
  logic [31:0] m_st = 32'h3C;
  always #5 clk = ~clk;
  flash_spi_front dut_u (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_SCK(sck), .I_CE_N(ce_n), .I_SI(si),
    .I_HOLD_N(hold_n), .I_WP_N(wp_n), .O_SO(so), .O_SO_OE(so_oe), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr), .I_WDATA(wd), .I_WSTRB(wstrb), .O_BVALID(bv),
    .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
    .O_RVALID(rv), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp));
  spi_host_model host_u (.i_so(so_w), .o_sck(sck), .o_ce_n(ce_n), .o_si(si), .o_hold_n(hold_n));
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int t = 0;
    @(posedge clk);
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= d;
    bready <= 1;
    do begin
      @(posedge clk);
      t++;
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end while (bv !== 1 && t < 50);
    bready <= 0;
    if (t >= 50) errors++;
    chk("bresp", er, bresp);
  endtask
  task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    int t = 0;
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rready <= 1;
    do begin
      @(posedge clk);
      t++;
      if (arr) arv <= 0;
    end while (rv !== 1 && t < 50);
    rready <= 0;
    d = rdata;
    r = rresp;
    if (t >= 50) errors++;
  endtask
  task automatic st_chk();
    logic [31:0] d;
    logic [1:0] r;
    axr(`REG_STATUS, d, r);
    chk("status", m_st, d);
  endtask
  task automatic spi(input bit m, input logic [7:0] c, input bit two, input logic [7:0] v,
      output logic [7:0] rx);
    logic [7:0] x;
    host_u.sel(m);
    host_u.xfer(c, x);
    if (two) host_u.xfer(v, rx);
    host_u.desel();
  endtask
  task automatic test_done();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    errors++;
    test_done();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] rx, v, t8;
    logic [23:0] a;
    repeat (16) @(posedge clk);
    arst_n <= 1;
    repeat (4) @(posedge clk);
    st_chk();
    axr(6'h18, d, r);
    chk("rresp", 2'h2, r);
    axw(`REG_STATUS, 32'h0, 2'h2);
    for (int m = 0; m < 2; m++) begin
      spi(m, `CMD_READ_STATUS, 1, 8'h00, rx);
      chk("so_status", m_st, rx);
      axr(`REG_RX, d, r);
      chk("mode", m, d[17]);
    end
    // lock set with pin high, refused with pin low, cleared, then written with pin low
    for (int k = 0; k < 4; k++) begin
      v = xs();
      if (k == 0) v[7] = 1;
      if (k == 2) v[7] = 0;
      wp_n <= !k[0];
      spi(0, `CMD_WRITE_ENABLE, 0, 8'h00, rx);
      m_st[1] = 1;
      st_chk();
      spi(0, `CMD_WRITE_STATUS, 1, v, rx);
      if (!k[0] || !m_st[7]) m_st = (m_st & 32'h43) | (v & 8'hBC);
      m_st[1] = 0;
      st_chk();
    end
    host_u.sel(0);
    host_u.xfer(`CMD_READ_STATUS, rx);
    host_u.hold(0);
    host_u.wig();
    chk("oe_paused", 0, so_oe);
    host_u.hold(1);
    host_u.xfer(8'h00, rx);
    chk("so_resume", m_st, rx);
    host_u.hold(0);
    host_u.desel();
    host_u.hold(1);
    spi(0, `CMD_READ_STATUS, 1, 8'h00, rx);
    chk("so_restart", m_st, rx);
    // read path: software byte follows command and three address bytes, one byte read
    a = {xs(), xs(), xs()};
    t8 = xs();
    axw(`REG_TX_DATA, {24'h000000, t8}, 2'h0);
    wstrb <= 4'h0;
    // lane 0 off, so the byte must stay
    axw(`REG_TX_DATA, {24'h000000, ~t8}, 2'h0);
    wstrb <= 4'hF;
    axr(`REG_TX_DATA, d, r);
    chk("tx_data", t8, d);
    host_u.sel(0);
    host_u.xfer(`CMD_READ_DATA, rx);
    for (int i = 2; i >= 0; i--) host_u.xfer(a[8*i+:8], rx);
    host_u.xfer(8'h00, rx);
    host_u.desel();
    chk("so_data", t8, rx);
    axr(`REG_ADDR, d, r);
    chk("addr", a, d);
    axr(`REG_GEOM, d, r);
    chk("geom", ((a >> 12) << 16) | (((a >> 15) & 8'hFF) << 8) | (a >> 16), d);
    // disable clears the enable latch
    spi(0, `CMD_WRITE_ENABLE, 0, 8'h00, rx);
    spi(0, `CMD_WRITE_DISABLE, 0, 8'h00, rx);
    st_chk();
    // software busy with ready/busy on: pin shows busy, status write refused
    axw(`REG_CTRL, 32'h7, 2'h0);
    m_st = m_st | 32'h41;
    axr(`REG_CTRL, d, r);
    chk("ctrl", 32'h7, d);
    st_chk();
    host_u.sel(0);
    chk("rb_oe", 1, so_oe);
    chk("rb_so", 0, so);
    host_u.desel();
    spi(0, `CMD_WRITE_ENABLE, 0, 8'h00, rx);
    spi(0, `CMD_WRITE_STATUS, 1, xs(), rx);
    st_chk();
    axw(`REG_CTRL, 32'h0, 2'h0);
    m_st = m_st & 32'hBE;
    st_chk();
    // second reset in mid-run restores the power-up status
    @(posedge clk);
    arst_n <= 0;
    repeat (3) @(posedge clk);
    arst_n <= 1;
    repeat (4) @(posedge clk);
    m_st = 32'h3C;
    st_chk();
    test_done();
  end
endmodule // test_serial_flash_spi_front_end
